// ==== dma_ctl_pkg.sv ====
package dma_ctl_pkg;

    // apb map, byte addresses
    localparam int PADDR_W = 12;
    localparam int CH_SEL_BIT = 5;
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_SRC = 5'h04;
    localparam logic [4:0] OFS_DST = 5'h08;
    localparam logic [4:0] OFS_RLD = 5'h0C;
    localparam logic [4:0] OFS_FWD = 5'h10;
    localparam logic [4:0] OFS_CNT = 5'h14;
    localparam logic [11:0] ADDR_STAT = 12'h040;

    // control register fields
    localparam int CTRL_FWDSRC_BIT = 0;
    localparam int CTRL_REQ_BIT = 2;
    localparam int CTRL_EN_BIT = 3;
    localparam int CTRL_SEL_LSB = 4;
    localparam int SEL_W = 4;

    // status register fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_LVL_LSB = 8;

    // reset values and stepping
    localparam logic [31:0] RST_PTR = 32'h0000_0000;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
    localparam int FIFO_DEPTH_DEF = 8;
    localparam int CNT_W_DEF = 16;

    typedef enum logic [2:0] {
        ENG_IDLE = 3'b001,
        ENG_READ = 3'b010,
        ENG_PUSH = 3'b100
    } eng_state_t;

endpackage : dma_ctl_pkg

// ==== xfer_fifo.sv ====
`timescale 1ns/1ps
module xfer_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [CW-1:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready = (cnt_r != CW'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rp_r];
    assign level = cnt_r;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

    // explicit wrap keeps non power of two depths correct
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + PW'(1);
            end
            if (pop) begin
                rp_r <= (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + PW'(1);
            end
            cnt_r <= cnt_r + CW'(push) - CW'(pop);
        end
    end

endmodule : xfer_fifo

// ==== dma_channel.sv ====
`timescale 1ns/1ps
module dma_channel
    import dma_ctl_pkg::*;
#(
    parameter int NUM_SRC = 16,
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // register writes
    input wire logic wr_ctrl,
    input wire logic wr_src,
    input wire logic wr_dst,
    input wire logic wr_rld,
    input wire logic [31:0] wdata,
    // request sources and engine
    input wire logic [NUM_SRC-1:0] req_lines,
    input wire logic start,
    // state
    output logic enable,
    output logic request,
    output logic [31:0] ctrl_rd,
    output logic [31:0] src_rd,
    output logic [31:0] dst_rd,
    output logic [CNT_W-1:0] rld_rd,
    output logic [31:0] fwd_rd,
    output logic [CNT_W-1:0] cnt_rd,
    output logic [31:0] src_addr,
    output logic [31:0] dst_addr
);
    logic fwd_src_r;
    logic en_r;
    logic req_r;
    logic [SEL_W-1:0] sel_r;
    logic [31:0] src_r;
    logic [31:0] dst_r;
    logic [CNT_W-1:0] rld_r;
    logic [31:0] fwd_r;
    logic [CNT_W-1:0] cnt_r;
    logic line_prev_r;
    logic line_now;
    logic line_rise;

    // a change of selection can look like an edge; software clears after it
    assign line_now = req_lines[sel_r];
    assign line_rise = line_now && !line_prev_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fwd_src_r <= 1'b0;
            sel_r <= '0;
            src_r <= RST_PTR;
            dst_r <= RST_PTR;
            rld_r <= '0;
        end else begin
            if (wr_ctrl) begin
                fwd_src_r <= wdata[CTRL_FWDSRC_BIT];
                sel_r <= wdata[CTRL_SEL_LSB +: SEL_W];
            end
            if (wr_src) begin
                src_r <= wdata;
            end
            if (wr_dst) begin
                dst_r <= wdata;
            end
            if (wr_rld) begin
                rld_r <= wdata[CNT_W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_prev_r <= 1'b0;
            req_r <= 1'b0;
        end else begin
            line_prev_r <= line_now;
            if (line_rise) begin
                req_r <= 1'b1;
            end else if (start) begin
                req_r <= 1'b0;
            end else if (wr_ctrl && !wdata[CTRL_REQ_BIT]) begin
                req_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r <= 1'b0;
            fwd_r <= RST_PTR;
            cnt_r <= '0;
        end else if (wr_ctrl) begin
            en_r <= wdata[CTRL_EN_BIT];
            if (wdata[CTRL_EN_BIT]) begin
                fwd_r <= wdata[CTRL_FWDSRC_BIT] ? src_r : dst_r;
                cnt_r <= rld_r;
            end
        end else if (start) begin
            fwd_r <= fwd_r + ADDR_STEP;
            cnt_r <= cnt_r - CNT_W'(1);
            if (cnt_r == CNT_W'(1)) begin
                en_r <= 1'b0;
            end
        end
    end

    assign enable = en_r;
    assign request = req_r;
    assign ctrl_rd = {{(32 - CTRL_SEL_LSB - SEL_W){1'b0}}, sel_r, en_r, req_r, 1'b0, fwd_src_r};
    assign src_rd = src_r;
    assign dst_rd = dst_r;
    assign rld_rd = rld_r;
    assign fwd_rd = fwd_r;
    assign cnt_rd = cnt_r;
    assign src_addr = fwd_src_r ? fwd_r : src_r;
    assign dst_addr = fwd_src_r ? dst_r : fwd_r;

endmodule : dma_channel

// ==== dma_channel_enable_request_control.sv ====
// Behaviour
// - control bit 3 is the enable flag; writing one activates the channel.
// - enabling copies the source pointer (control bit 0 set) or the destination pointer into the working forward pointer.
// - enabling loads the working transfer counter from the reload register.
// - enabling an active channel restarts it, discarding progress.
// - control bit 2 is the request flag, separate from enable.
// - a request from the selected source sets the flag, enabled or not.
// - hardware clears the request flag when the transfer starts.
// - software can clear the request flag but never set it.
// - a request on an enabled channel starts the transfer once the engine is idle; channel 0 wins a tie.
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
module dma_channel_enable_request_control
    import dma_ctl_pkg::*;
#(
    parameter int NUM_SRC = 16,
    parameter int CNT_W = CNT_W_DEF,
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // peripheral request lines, same clock
    input wire logic [NUM_SRC-1:0] req_lines,
    // memory read port
    output logic mrd_valid,
    output logic [31:0] mrd_addr,
    input wire logic mrd_ready,
    input wire logic [31:0] mrd_data,
    // memory write port
    output logic mwr_valid,
    output logic [31:0] mwr_addr,
    output logic [31:0] mwr_data,
    input wire logic mwr_ready
);
    localparam int NCH = 2;
    localparam int LVL_W = $clog2(FIFO_DEPTH + 1);

    // apb handshake
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic access;
    logic wr_fire;
    logic [4:0] off;
    logic in_ch_space;
    logic ch_idx;
    logic hit_stat;
    logic mapped;
    logic [31:0] rd_mux;

    // per channel wiring
    logic [NCH-1:0] wr_ctrl;
    logic [NCH-1:0] wr_src;
    logic [NCH-1:0] wr_dst;
    logic [NCH-1:0] wr_rld;
    logic [NCH-1:0] ch_en;
    logic [NCH-1:0] ch_req;
    logic [NCH-1:0] cand;
    logic [NCH-1:0] start;
    logic [31:0] ctrl_rd [NCH];
    logic [31:0] src_rd [NCH];
    logic [31:0] dst_rd [NCH];
    logic [CNT_W-1:0] rld_rd [NCH];
    logic [31:0] fwd_rd [NCH];
    logic [CNT_W-1:0] cnt_rd [NCH];
    logic [31:0] src_addr [NCH];
    logic [31:0] dst_addr [NCH];

    // transfer engine
    eng_state_t state_r;
    eng_state_t state_nxt;
    logic mrd_valid_r;
    logic [31:0] mrd_addr_r;
    logic [31:0] dst_hold_r;
    logic [31:0] data_hold_r;

    // fifo and write stage
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [63:0] fifo_out_data;
    logic [LVL_W-1:0] fifo_level;
    logic mwr_valid_r;
    logic [31:0] mwr_addr_r;
    logic [31:0] mwr_data_r;

    // address decode
    assign access = psel && penable;
    assign wr_fire = access && pready_r && pwrite;
    assign off = paddr[4:0];
    assign in_ch_space = (paddr[PADDR_W-1:CH_SEL_BIT+1] == '0);
    assign ch_idx = paddr[CH_SEL_BIT];
    assign hit_stat = (paddr == ADDR_STAT);

    always_comb begin
        mapped = 1'b0;
        rd_mux = RST_WORD;
        if (hit_stat) begin
            mapped = 1'b1;
            rd_mux[STAT_BUSY_BIT] = (state_r != ENG_IDLE) || fifo_out_valid || mwr_valid_r;
            rd_mux[STAT_LVL_LSB +: LVL_W] = fifo_level;
        end else if (in_ch_space) begin
            mapped = 1'b1;
            case (off)
                OFS_CTRL: begin
                    rd_mux = ctrl_rd[ch_idx];
                end
                OFS_SRC: begin
                    rd_mux = src_rd[ch_idx];
                end
                OFS_DST: begin
                    rd_mux = dst_rd[ch_idx];
                end
                OFS_RLD: begin
                    rd_mux[CNT_W-1:0] = rld_rd[ch_idx];
                end
                OFS_FWD: begin
                    rd_mux = fwd_rd[ch_idx];
                end
                OFS_CNT: begin
                    rd_mux[CNT_W-1:0] = cnt_rd[ch_idx];
                end
                default: begin
                    mapped = 1'b0;
                end
            endcase
        end
    end

    // one wait state so every apb output is a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= RST_WORD;
        end else begin
            pready_r <= access && !pready_r;
            if (access && !pready_r) begin
                pslverr_r <= !mapped;
                prdata_r <= pwrite ? RST_WORD : rd_mux;
            end else begin
                pslverr_r <= 1'b0;
            end
        end
    end

    // channel instances share nothing
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ch
            logic sel_me;
            assign sel_me = wr_fire && in_ch_space && (ch_idx == 1'(gi));
            assign wr_ctrl[gi] = sel_me && (off == OFS_CTRL);
            assign wr_src[gi] = sel_me && (off == OFS_SRC);
            assign wr_dst[gi] = sel_me && (off == OFS_DST);
            assign wr_rld[gi] = sel_me && (off == OFS_RLD);
            // a control write in flight owns the pointers this cycle
            assign cand[gi] = ch_en[gi] && ch_req[gi] && !wr_ctrl[gi];

            dma_channel #(
                .NUM_SRC(NUM_SRC),
                .CNT_W(CNT_W)
            ) u_ch (
                .pclk(pclk),
                .presetn(presetn),
                .wr_ctrl(wr_ctrl[gi]),
                .wr_src(wr_src[gi]),
                .wr_dst(wr_dst[gi]),
                .wr_rld(wr_rld[gi]),
                .wdata(pwdata),
                .req_lines(req_lines),
                .start(start[gi]),
                .enable(ch_en[gi]),
                .request(ch_req[gi]),
                .ctrl_rd(ctrl_rd[gi]),
                .src_rd(src_rd[gi]),
                .dst_rd(dst_rd[gi]),
                .rld_rd(rld_rd[gi]),
                .fwd_rd(fwd_rd[gi]),
                .cnt_rd(cnt_rd[gi]),
                .src_addr(src_addr[gi]),
                .dst_addr(dst_addr[gi])
            );
        end
    endgenerate

    // fixed priority, first channel wins a tie
    assign start[0] = (state_r == ENG_IDLE) && cand[0];
    assign start[1] = (state_r == ENG_IDLE) && cand[1] && !cand[0];

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ENG_IDLE: begin
                if (|start) begin
                    state_nxt = ENG_READ;
                end
            end
            ENG_READ: begin
                if (mrd_ready) begin
                    state_nxt = ENG_PUSH;
                end
            end
            ENG_PUSH: begin
                if (fifo_in_ready) begin
                    state_nxt = ENG_IDLE;
                end
            end
            default: begin
                state_nxt = ENG_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ENG_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // addresses are latched at start so a restart cannot bend a beat in flight
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mrd_valid_r <= 1'b0;
            mrd_addr_r <= RST_PTR;
            dst_hold_r <= RST_PTR;
            data_hold_r <= RST_WORD;
        end else begin
            if (state_r == ENG_IDLE && (|start)) begin
                mrd_valid_r <= 1'b1;
                mrd_addr_r <= start[0] ? src_addr[0] : src_addr[1];
                dst_hold_r <= start[0] ? dst_addr[0] : dst_addr[1];
            end else if (state_r == ENG_READ && mrd_ready) begin
                mrd_valid_r <= 1'b0;
                data_hold_r <= mrd_data;
            end
        end
    end

    // full fifo holds the engine in push, so no new start is taken
    assign fifo_in_valid = (state_r == ENG_PUSH);
    assign fifo_out_ready = !mwr_valid_r || mwr_ready;

    xfer_fifo #(
        .WIDTH(64),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data({dst_hold_r, data_hold_r}),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data),
        .level(fifo_level)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mwr_valid_r <= 1'b0;
            mwr_addr_r <= RST_PTR;
            mwr_data_r <= RST_WORD;
        end else if (fifo_out_valid && fifo_out_ready) begin
            mwr_valid_r <= 1'b1;
            mwr_addr_r <= fifo_out_data[63:32];
            mwr_data_r <= fifo_out_data[31:0];
        end else if (mwr_ready) begin
            mwr_valid_r <= 1'b0;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign mrd_valid = mrd_valid_r;
    assign mrd_addr = mrd_addr_r;
    assign mwr_valid = mwr_valid_r;
    assign mwr_addr = mwr_addr_r;
    assign mwr_data = mwr_data_r;

endmodule : dma_channel_enable_request_control

// ==== dma_ctl_props.sv ====
`timescale 1ns/1ps
module dma_ctl_props
    import dma_ctl_pkg::*;
(
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // memory ports
    input wire logic mrd_valid,
    input wire logic [31:0] mrd_addr,
    input wire logic mrd_ready,
    input wire logic mwr_valid,
    input wire logic [31:0] mwr_addr,
    input wire logic [31:0] mwr_data,
    input wire logic mwr_ready
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic unmapped;
    logic rd_ok;
    // holes at +0x18 and +0x1C of each channel window
    assign unmapped = paddr[1:0] != 2'h0 || paddr > 12'h040 || (paddr < 12'h040 && paddr[4:0] > 5'h14);
    assign rd_ok = pready && !pwrite && !unmapped && paddr < 12'h040;
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && !pready ##1 psel && penable && pready;
    endsequence
    property p_wait; s_setup |=> s_access; endproperty
    a_wait: assert property (p_wait) else $error("apb wait state wrong");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
    property p_map; pready |-> pslverr == unmapped; endproperty
    a_map: assert property (p_map) else $error("slave error does not match map");
    property p_err_zero; pready && (pslverr || pwrite) |-> prdata == 32'h0000_0000; endproperty
    a_err_zero: assert property (p_err_zero) else $error("read data not zero");
    property p_ctrl_fields; rd_ok && paddr[4:0] == 5'h00 |-> prdata[1] == 1'b0 && prdata[31:8] == 24'h0; endproperty
    a_ctrl_fields: assert property (p_ctrl_fields) else $error("control reserved bits set");
    property p_cnt_width; rd_ok && paddr[3:0] == 4'hC |-> prdata[31:16] == 16'h0; endproperty
    a_cnt_width: assert property (p_cnt_width) else $error("count wider than its field");
    property p_rd_hold; mrd_valid && !mrd_ready |=> mrd_valid && $stable(mrd_addr); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read request dropped");
    property p_wr_hold; mwr_valid && !mwr_ready |=> mwr_valid && $stable(mwr_addr) && $stable(mwr_data); endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write request dropped");
    property p_one_read; mrd_valid && mrd_ready |=> !mrd_valid; endproperty
    a_one_read: assert property (p_one_read) else $error("second read in flight");
endmodule : dma_ctl_props
bind dma_channel_enable_request_control dma_ctl_props i_dma_ctl_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mrd_valid(mrd_valid), .mrd_addr(mrd_addr), .mrd_ready(mrd_ready),
    .mwr_valid(mwr_valid), .mwr_addr(mwr_addr), .mwr_data(mwr_data), .mwr_ready(mwr_ready));

// ==== mem_model.sv ====
`timescale 1ns/1ps
module mem_model #(
    parameter logic [31:0] KEY = 32'h0000_0000
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pacing
    input wire logic rd_slow,
    input wire logic wr_stall,
    // read port
    input wire logic mrd_valid,
    input wire logic [31:0] mrd_addr,
    output logic mrd_ready,
    output logic [31:0] mrd_data,
    // write port
    input wire logic mwr_valid,
    input wire logic [31:0] mwr_addr,
    input wire logic [31:0] mwr_data,
    output logic mwr_ready,
    // record
    output logic [7:0] wr_cnt,
    output logic [31:0] last_waddr,
    output logic [31:0] last_wdata
);
    logic tgl_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tgl_r <= 1'b0;
            mrd_ready <= 1'b0;
            mrd_data <= 32'h0000_0000;
            mwr_ready <= 1'b0;
        end else begin
            tgl_r <= !tgl_r;
            // slow mode answers on every other cycle only
            mrd_ready <= mrd_valid && !mrd_ready && !(rd_slow && tgl_r);
            // flips when idle so a stray sample never looks right
            mrd_data <= (mrd_valid && !mrd_ready) ? (mrd_addr ^ KEY) : ~mrd_data;
            mwr_ready <= mwr_valid && !mwr_ready && !wr_stall;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_cnt <= 8'h00;
            last_waddr <= 32'h0000_0000;
            last_wdata <= 32'h0000_0000;
        end else if (mwr_valid && mwr_ready) begin
            wr_cnt <= wr_cnt + 8'h01;
            last_waddr <= mwr_addr;
            last_wdata <= mwr_data;
        end
    end
endmodule : mem_model

// ==== test_dma_channel_enable_request_control.sv ====
`timescale 1ns/1ps
module test_dma_channel_enable_request_control
    import dma_ctl_pkg::*;
;
    localparam logic [31:0] KEY = 32'hA5A5_0000;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
    logic mrd_valid, mrd_ready, mwr_valid, mwr_ready, rd_slow, wr_stall;
    logic [PADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, mrd_addr, mrd_data, mwr_addr, mwr_data, last_waddr, last_wdata;
    logic [31:0] rd_data, seed, s0, d0, s1, d1, r;
    logic [15:0] req_lines;
    logic [7:0] wr_cnt;
    logic [3:0] sel0, sel1;
    int error_cnt, comparisons;
    dma_channel_enable_request_control i_dma_channel_enable_request_control (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .req_lines(req_lines), .mrd_valid(mrd_valid), .mrd_addr(mrd_addr),
        .mrd_ready(mrd_ready), .mrd_data(mrd_data), .mwr_valid(mwr_valid), .mwr_addr(mwr_addr),
        .mwr_data(mwr_data), .mwr_ready(mwr_ready));
    mem_model #(.KEY(KEY)) i_mem_model (.pclk(pclk), .presetn(presetn), .rd_slow(rd_slow),
        .wr_stall(wr_stall), .mrd_valid(mrd_valid), .mrd_addr(mrd_addr), .mrd_ready(mrd_ready),
        .mrd_data(mrd_data), .mwr_valid(mwr_valid), .mwr_addr(mwr_addr), .mwr_data(mwr_data),
        .mwr_ready(mwr_ready), .wr_cnt(wr_cnt), .last_waddr(last_waddr), .last_wdata(last_wdata));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [31:0] ctl(input logic [3:0] sel, input logic en, input logic req, input logic src);
        return {24'h0, sel, en, req, 1'b0, src};
    endfunction : ctl
    function automatic logic [11:0] ra(input logic ch, input logic [4:0] ofs);
        return {6'h00, ch, ofs};
    endfunction : ra
    task automatic stop_test();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd_data);
    endtask : rd_chk
    task automatic pulse(input logic [3:0] sel);
        @(posedge pclk);
        req_lines <= 16'h0001 << sel;
        @(posedge pclk);
        req_lines <= 16'h0000;
    endtask : pulse
    task automatic wait_wr(input logic [7:0] n);
        int i;
        i = 0;
        while (wr_cnt !== n && i < 300) begin
            @(posedge pclk);
            i++;
        end
        chk("write count", n, wr_cnt);
    endtask : wait_wr
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        repeat (5000) @(posedge pclk);
        error_cnt++;
        stop_test();
    end
    initial begin
        {presetn, psel, penable, pwrite, rd_slow, wr_stall} = 6'h00;
        paddr = '0;
        pwdata = 32'h0;
        req_lines = 16'h0;
        seed = 32'h0018;
        error_cnt = 0;
        comparisons = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("ctrl reset", ra(0, OFS_CTRL), 32'h0);
        apb(1'b0, 12'h018, 32'h0);
        chk("unmapped error", 1, rd_err);
        s0 = rnd() & ~32'h3;
        d0 = rnd() & ~32'h3;
        s1 = rnd() & ~32'h3;
        d1 = rnd() & ~32'h3;
        r = rnd();
        sel0 = r[3:0];
        sel1 = sel0 ^ 4'h8;
        apb(1'b1, ra(0, OFS_SRC), s0);
        apb(1'b1, ra(0, OFS_DST), d0);
        apb(1'b1, ra(0, OFS_RLD), 32'h3);
        apb(1'b1, ra(1, OFS_SRC), s1);
        apb(1'b1, ra(1, OFS_DST), d1);
        apb(1'b1, ra(1, OFS_RLD), 32'h2);
        apb(1'b1, ra(0, OFS_CTRL), ctl(sel0, 1, 0, 1));
        rd_chk("ctrl0", ra(0, OFS_CTRL), ctl(sel0, 1, 0, 1));
        rd_chk("fwd0 load", ra(0, OFS_FWD), s0);
        rd_chk("cnt0 load", ra(0, OFS_CNT), 32'h3);
        pulse(sel0);
        wait_wr(8'd1);
        chk("waddr0", d0, last_waddr);
        chk("wdata0", s0 ^ KEY, last_wdata);
        rd_chk("ctrl0 after start", ra(0, OFS_CTRL), ctl(sel0, 1, 0, 1));
        rd_chk("fwd0 step", ra(0, OFS_FWD), s0 + 32'h4);
        rd_chk("cnt0 step", ra(0, OFS_CNT), 32'h2);
        apb(1'b1, ra(0, OFS_CTRL), ctl(sel0, 1, 0, 1));
        rd_chk("fwd0 restart", ra(0, OFS_FWD), s0);
        rd_chk("cnt0 restart", ra(0, OFS_CNT), 32'h3);
        rd_chk("cnt1 untouched", ra(1, OFS_CNT), 32'h0);
        rd_chk("rld1", ra(1, OFS_RLD), 32'h2);
        rd_chk("src1 untouched", ra(1, OFS_SRC), s1);
        apb(1'b1, ra(1, OFS_CTRL), ctl(sel1, 0, 0, 0));
        apb(1'b1, ra(1, OFS_CTRL), ctl(sel1, 0, 0, 0));
        pulse(sel1);
        repeat (4) @(posedge pclk);
        rd_chk("ctrl1 pending", ra(1, OFS_CTRL), ctl(sel1, 0, 1, 0));
        chk("no transfer while off", 8'd1, wr_cnt);
        apb(1'b1, ra(1, OFS_CTRL), ctl(sel1, 0, 0, 0));
        rd_chk("ctrl1 cleared", ra(1, OFS_CTRL), ctl(sel1, 0, 0, 0));
        apb(1'b1, ra(1, OFS_CTRL), ctl(sel1, 0, 1, 0));
        rd_chk("ctrl1 not set", ra(1, OFS_CTRL), ctl(sel1, 0, 0, 0));
        pulse(sel1);
        repeat (4) @(posedge pclk);
        apb(1'b1, ra(1, OFS_CTRL), ctl(sel1, 1, 1, 0));
        wait_wr(8'd2);
        chk("waddr1", d1, last_waddr);
        chk("wdata1", s1 ^ KEY, last_wdata);
        rd_chk("cnt1 step", ra(1, OFS_CNT), 32'h1);
        pulse(sel1);
        wait_wr(8'd3);
        chk("waddr1 step", d1 + 32'h4, last_waddr);
        rd_chk("ctrl1 done", ra(1, OFS_CTRL), ctl(sel1, 0, 0, 0));
        wr_stall <= 1'b1;
        apb(1'b1, ra(0, OFS_RLD), 32'h40);
        apb(1'b1, ra(0, OFS_CTRL), ctl(sel0, 1, 0, 1));
        for (int k = 0; k < 10; k++) begin
            r = rnd();
            rd_slow <= r[0];
            pulse(sel0);
            repeat (12) @(posedge pclk);
        end
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("fifo full level", 32'h8, (rd_data >> STAT_LVL_LSB) & 32'hF);
        wr_stall <= 1'b0;
        wait_wr(8'd13);
        chk("wdata last", (s0 + 32'd36) ^ KEY, last_wdata);
        rd_chk("status idle", ADDR_STAT, 32'h0);
        apb(1'b1, ra(0, OFS_CTRL), ctl(sel0, 0, 0, 1));
        pulse(sel0);
        repeat (12) @(posedge pclk);
        rd_chk("ctrl0 disabled", ra(0, OFS_CTRL), ctl(sel0, 0, 1, 1));
        chk("no transfer after disable", 8'd13, wr_cnt);
        stop_test();
    end
endmodule : test_dma_channel_enable_request_control
